// ### core/standby_pkg.sv
// package: constants, types and register map for the standby mode controller
package standby_pkg;

	// register byte offsets on the control bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_SETTLE = 8'h10;
	localparam logic [7:0] OFF_PERIPH = 8'h14;

	// ctrl register fields
	localparam int CTRL_LSO_SW_STOP = 0;
	localparam int CTRL_LSO_RUN = 1;

	// peripheral clock select fields
	localparam int PS_TMA_PIN = 0;
	localparam int PS_TMB_PIN = 1;
	localparam int PS_ITA_FROM_TMA = 2;
	localparam int PS_ITB_SLOW = 3;
	localparam int PS_SERA_FROM_TMA = 4;
	localparam int PS_SERB_FROM_TMA = 5;
	localparam int PS_CSU_EXT = 6;
	localparam int PS_TMA_RUN = 7;

	// event bits in the interrupt status register
	localparam int EV_HALT_ENTER = 0;
	localparam int EV_STOP_ENTER = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_STOP_FALLBACK = 3;
	localparam int EV_W = 4;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0002;
	localparam logic [31:0] SETTLE_RST = 32'h0000_0100;
	localparam logic [31:0] PERIPH_RST = 32'h0000_0000;

	// wake waits, counted in cpu clocks (lower figure of each pair)
	localparam int WAIT_VECT_CLK = 11;
	localparam int WAIT_NEXT_CLK = 4;
	localparam logic [15:0] WAIT_VECT = 16'(WAIT_VECT_CLK);
	localparam logic [15:0] WAIT_NEXT = 16'(WAIT_NEXT_CLK);

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {
		ST_RUN,
		ST_HALT,
		ST_STOP,
		ST_SETTLE,
		ST_WAKE_WAIT
	} standby_state_e;

	// clock and peripheral gates toward the chip
	typedef struct packed {
		logic cpu_clk_en;
		logic fast_internal_clock_en;
		logic crystal_clock_en;
		logic ext_main_clk_accept;
		logic slow_internal_clock_en;
		logic flash_en;
		logic wdt_clk_en;
		logic timer16_en;
		logic adc_en;
		logic two_wire_serial_unit_en;
		logic timer_a_en;
		logic timer_b_en;
		logic interval_timer_a_en;
		logic interval_timer_b_en;
		logic async_serial_a_en;
		logic async_serial_b_en;
		logic clocked_serial_unit_en;
		logic por_lvd_extint_en;
	} gate_s;

	// per-request interrupt flags from the interrupt controller
	typedef struct packed {
		logic pending;
		logic irq_mask_flag;
		logic irq_priority_flag;
	} irq_req_s;

endpackage

// ### core/standby_mode_controller.sv
// standby mode controller: halt and stop entry, release, clock and peripheral gating
//
// Overview of operation
// - halt ends on any unmasked pending request
// - wake goes vectored if accepted, else next
// - wait 11 clocks vectored, 4 clocks next
// - reset during halt ends halt, restarts
// - mask held; priority needs accept and in-service
// - stop instruction enters stop mode
// - stop accepted from any cpu clock source
// - pending unmasked request turns stop into settle, then wake wait
// - stop gates cpu, fast, crystal, external clocks
// - slow oscillator kept, cpu flash halted
// - stop halts 16-bit timer, adc, two-wire
// - timer a runs on its pin only
// - timer b runs on its pin only
// - interval timer a runs from running timer a
// - interval timer b runs on slow clock
// - watchdog runs unless slow oscillator software-stoppable
// - async serial units run from running timer a
// - clocked serial unit runs on external clock
`timescale 1ns/10ps
module standby_mode_controller #(
	parameter int N_IRQ = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// cpu core
	input wire logic halt_instr_i,
	input wire logic stop_instr_i,
	input wire logic global_irq_accept_i,
	input wire logic in_service_priority_flag_i,
	output logic cpu_resume_o,
	output logic cpu_vector_o,
	// interrupt controller
	input wire standby_pkg::irq_req_s [N_IRQ-1:0] irq_req_i,
	// clock and peripheral gates
	output standby_pkg::gate_s gate_o,
	output logic [2:0] mode_o,
	output logic irq_o,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import standby_pkg::*;

	standby_state_e state_r;
	standby_state_e state_nxt;
	logic [15:0] cnt_r;
	logic vect_r;
	logic [31:0] ctrl_r;
	logic [31:0] settle_r;
	logic [31:0] periph_r;
	logic [EV_W-1:0] ev_stat_r;
	logic [EV_W-1:0] ev_mask_r;
	logic [EV_W-1:0] ev_set;
	logic wake_req;
	logic wake_vect;
	logic [7:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic wr_go;

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// wake decision over all requests; a masked one never wakes
	always_comb begin
		wake_req = 1'b0;
		wake_vect = 1'b0;
		for (int i = 0; i < N_IRQ; i++) begin
			if (irq_req_i[i].pending && !irq_req_i[i].irq_mask_flag) begin
				wake_req = 1'b1;
				if (!irq_req_i[i].irq_priority_flag) begin
					if (global_irq_accept_i) begin
						wake_vect = 1'b1;
					end
				end else if (global_irq_accept_i && in_service_priority_flag_i) begin
					wake_vect = 1'b1;
				end
			end
		end
	end

	// next state of the standby sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (stop_instr_i) begin
					// no clock-source check: stop is taken from any cpu clock
					state_nxt = wake_req ? ST_SETTLE : ST_STOP;
				end else if (halt_instr_i) begin
					state_nxt = ST_HALT;
				end
			end
			ST_HALT: begin
				if (wake_req) begin
					state_nxt = ST_WAKE_WAIT;
				end
			end
			ST_STOP: begin
				if (wake_req) begin
					state_nxt = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = ST_WAKE_WAIT;
				end
			end
			ST_WAKE_WAIT: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	// state register; reset always lands in run, from halt or stop alike
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// wait counter and vector decision latched at wake
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt_r <= 16'h0000;
			vect_r <= 1'b0;
		end else if (state_r != ST_SETTLE && state_nxt == ST_SETTLE) begin
			cnt_r <= settle_r[15:0];
		end else if (state_r != ST_WAKE_WAIT && state_nxt == ST_WAKE_WAIT) begin
			vect_r <= wake_vect;
			// count of n is loaded as n-1, reaches zero after n-1 cycles, then one more to resume
			cnt_r <= wake_vect ? WAIT_VECT - 16'h0001 : WAIT_NEXT - 16'h0001;
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	// resume pulse toward the cpu, vector flag held beside it
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cpu_resume_o <= 1'b0;
			cpu_vector_o <= 1'b0;
		end else begin
			cpu_resume_o <= (state_r == ST_WAKE_WAIT) && (cnt_r == 16'h0000);
			cpu_vector_o <= vect_r;
		end
	end

	// clock and peripheral gating from mode and selects
	always_ff @(posedge clk_sys_i) begin
		logic stp;
		logic tma_run;
		stp = (state_nxt == ST_STOP);
		tma_run = !stp || periph_r[PS_TMA_PIN];
		if (reset_i) begin
			gate_o <= '0;
			mode_o <= 3'h0;
		end else begin
			mode_o <= {state_nxt == ST_WAKE_WAIT || state_nxt == ST_SETTLE, stp,
				state_nxt == ST_HALT};
			gate_o.cpu_clk_en <= (state_nxt == ST_RUN);
			gate_o.fast_internal_clock_en <= !stp;
			gate_o.crystal_clock_en <= !stp;
			gate_o.ext_main_clk_accept <= !stp;
			gate_o.slow_internal_clock_en <= ctrl_r[CTRL_LSO_RUN];
			gate_o.flash_en <= (state_nxt == ST_RUN);
			// the watchdog loses its clock only while the slow oscillator may be stopped
			gate_o.wdt_clk_en <= !(stp && ctrl_r[CTRL_LSO_SW_STOP]);
			gate_o.timer16_en <= !stp;
			gate_o.adc_en <= !stp;
			gate_o.two_wire_serial_unit_en <= !stp;
			gate_o.timer_a_en <= tma_run;
			gate_o.timer_b_en <= !stp || periph_r[PS_TMB_PIN];
			gate_o.interval_timer_a_en <= !stp || (periph_r[PS_ITA_FROM_TMA] && tma_run
				&& periph_r[PS_TMA_RUN]);
			gate_o.interval_timer_b_en <= !stp || periph_r[PS_ITB_SLOW];
			gate_o.async_serial_a_en <= !stp || (periph_r[PS_SERA_FROM_TMA] && tma_run
				&& periph_r[PS_TMA_RUN]);
			gate_o.async_serial_b_en <= !stp || (periph_r[PS_SERB_FROM_TMA] && tma_run
				&& periph_r[PS_TMA_RUN]);
			gate_o.clocked_serial_unit_en <= !stp || periph_r[PS_CSU_EXT];
			gate_o.por_lvd_extint_en <= 1'b1;
		end
	end

	// event sources for the sticky status bits
	always_comb begin
		ev_set = '0;
		ev_set[EV_HALT_ENTER] = (state_r == ST_RUN) && (state_nxt == ST_HALT);
		ev_set[EV_STOP_ENTER] = (state_r == ST_RUN) && (state_nxt == ST_STOP);
		ev_set[EV_WAKE] = (state_r == ST_WAKE_WAIT) && (state_nxt == ST_RUN);
		ev_set[EV_STOP_FALLBACK] = (state_r == ST_RUN) && stop_instr_i && wake_req;
	end

	// axi write: address and data taken in either order, one at a time
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_r)
					OFF_CTRL, OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_SETTLE, OFF_PERIPH: begin
						s_axi_bresp <= RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ctrl_r <= CTRL_RST;
			settle_r <= SETTLE_RST;
			periph_r <= PERIPH_RST;
			ev_mask_r <= '0;
		end else if (wr_go) begin
			case (aw_addr_r)
				OFF_CTRL: ctrl_r <= merge_bytes(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0003;
				OFF_SETTLE: settle_r <= merge_bytes(settle_r, w_data_r, w_strb_r)
					& 32'h0000_FFFF;
				OFF_PERIPH: periph_r <= merge_bytes(periph_r, w_data_r, w_strb_r)
					& 32'h0000_00FF;
				OFF_IRQ_MASK: ev_mask_r <= w_data_r[EV_W-1:0] & {EV_W{w_strb_r[0]}};
				default: begin
				end
			endcase
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ev_stat_r <= '0;
		end else if (wr_go && aw_addr_r == OFF_IRQ_STAT && w_strb_r[0]) begin
			ev_stat_r <= (ev_stat_r & ~w_data_r[EV_W-1:0]) | ev_set;
		end else begin
			ev_stat_r <= ev_stat_r | ev_set;
		end
	end

	assign irq_o = |(ev_stat_r & ev_mask_r);

	// axi read: one beat, answered the cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				OFF_CTRL: s_axi_rdata <= ctrl_r;
				OFF_STATUS: s_axi_rdata <= {26'h0, vect_r, cnt_r == 16'h0000, 1'b0, mode_o};
				OFF_IRQ_STAT: s_axi_rdata <= {28'h0, ev_stat_r};
				OFF_IRQ_MASK: s_axi_rdata <= {28'h0, ev_mask_r};
				OFF_SETTLE: s_axi_rdata <= settle_r;
				OFF_PERIPH: s_axi_rdata <= periph_r;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ### sim/cpu_irq_model.sv
// partner model: cpu core instructions and interrupt controller flags
`timescale 1ns/10ps
module cpu_irq_model #(
	parameter int N_IRQ = 8
) (
	// clock
	input wire logic clk_sys_i,
	// toward the controller
	output logic halt_instr_o,
	output logic stop_instr_o,
	output logic accept_o,
	output logic in_service_o,
	output standby_pkg::irq_req_s [N_IRQ-1:0] irq_o
);
	import standby_pkg::*;
	// quiet at time zero, no request pending
	initial begin
		halt_instr_o = 1'b0;
		stop_instr_o = 1'b0;
		accept_o = 1'b0;
		in_service_o = 1'b0;
		irq_o = '0;
	end
	// one-cycle instruction pulse, s picks stop
	task automatic exec(input logic s);
		@(posedge clk_sys_i);
		halt_instr_o <= !s;
		stop_instr_o <= s;
		@(posedge clk_sys_i);
		halt_instr_o <= 1'b0;
		stop_instr_o <= 1'b0;
	endtask
	// request 0 flags; pending stays up until dropped, as a real flag would
	task automatic flags(input logic p, m, pr, a, i);
		@(posedge clk_sys_i);
		irq_o[0] <= {p, m, pr};
		accept_o <= a;
		in_service_o <= i;
	endtask
endmodule

// ### sim/standby_mode_controller_monitor.sv
// checker: standby entry, release and stop gating
`timescale 1ns/10ps
module standby_mode_controller_monitor #(
	parameter int N_IRQ = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// cpu side
	input wire logic halt_instr_i,
	input wire logic stop_instr_i,
	input wire logic cpu_resume_o,
	// requests and gates
	input wire standby_pkg::irq_req_s [N_IRQ-1:0] irq_req_i,
	input wire standby_pkg::gate_s gate_o,
	input wire logic [2:0] mode_o
);
	import standby_pkg::*;
	logic wake;
	// any unmasked pending request
	always_comb begin
		wake = 1'b0;
		for (int i = 0; i < N_IRQ; i++) begin
			wake = wake | (irq_req_i[i].pending & ~irq_req_i[i].irq_mask_flag);
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	AST_STOP_IN: assert property (mode_o == 3'h0 && stop_instr_i && !wake
		|=> mode_o == 3'h2)
		else $error("stop not entered");
	AST_FALLBACK: assert property (mode_o == 3'h0 && stop_instr_i && wake
		|=> mode_o == 3'h4)
		else $error("stop did not fall back");
	// halt taken in run even with a request already pending
	AST_HALT_IN: assert property (mode_o == 3'h0 && halt_instr_i && !stop_instr_i
		|=> mode_o == 3'h1)
		else $error("halt not entered");
	AST_MASK_HOLD: assert property (mode_o == 3'h1 && !wake |=> mode_o == 3'h1)
		else $error("halt left without request");
	AST_WAKE: assert property (mode_o == 3'h1 && wake |-> ##[4:16] cpu_resume_o)
		else $error("no resume after wake");
	AST_PULSE: assert property (cpu_resume_o |=> !cpu_resume_o)
		else $error("resume not a pulse");
	AST_STOP_CLK: assert property (mode_o[1] |-> gate_o[17:14] == 4'h0)
		else $error("clock alive in stop");
	AST_STOP_CORE: assert property (mode_o[1] |-> !gate_o.flash_en
		&& gate_o.slow_internal_clock_en == $past(gate_o.slow_internal_clock_en))
		else $error("core or slow osc wrong in stop");
	AST_STOP_PER: assert property (mode_o[1] |-> gate_o[10:8] == 3'h0)
		else $error("peripheral alive in stop");
	AST_KEEP_WAKE: assert property (mode_o[1] |-> gate_o.por_lvd_extint_en)
		else $error("wake sources off in stop");
endmodule
bind standby_mode_controller standby_mode_controller_monitor #(.N_IRQ(N_IRQ)) u_mon (
	.clk_sys_i, .reset_i, .halt_instr_i, .stop_instr_i, .cpu_resume_o,
	.irq_req_i, .gate_o, .mode_o);

// ### sim/standby_mode_controller_tb_top.sv
// testbench: halt release table, stop gating, fallback, registers
`timescale 1ns/10ps
module standby_mode_controller_tb_top;
	import standby_pkg::*;
	// row bits: mask, prio, accept, in-service, wakes, vectored
	// any unmasked row wakes; only the accepted rows go vectored
	localparam logic [5:0] ROWS [6] = '{6'h02, 6'h0B, 6'h16, 6'h1A, 6'h1F, 6'h20};
	logic clk_sys_i = 1'b0, reset_i = 1'b1, cpu_resume_o, cpu_vector_o, irq_o;
	logic halt, stop, acc, in_srv;
	logic [3:0] wstrb = 4'hF;
	irq_req_s [3:0] irq;
	gate_s gate_o;
	logic [2:0] mode_o;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, rs;
	int fail_count = 0, n_checks = 0, c;
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	cpu_irq_model #(.N_IRQ(4)) u_cpu (.clk_sys_i, .halt_instr_o(halt), .stop_instr_o(stop),
		.accept_o(acc), .in_service_o(in_srv), .irq_o(irq));
	standby_mode_controller #(.N_IRQ(4)) u_dut (.clk_sys_i, .reset_i, .halt_instr_i(halt),
		.stop_instr_i(stop), .global_irq_accept_i(acc), .in_service_priority_flag_i(in_srv),
		.cpu_resume_o, .cpu_vector_o, .irq_req_i(irq), .gate_o, .mode_o, .irq_o,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
		logic ad, wd;
		// one idle edge keeps bready from being lowered and raised in one step
		@(posedge clk_sys_i);
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk_sys_i);
			if (awready && !ad) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !wd) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys_i); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys_i); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk_sys_i);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic rst();
		reset_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask
	task automatic wait_res(input int m);
		c = 0;
		while (!cpu_resume_o && c < m) begin
			@(posedge clk_sys_i);
			c++;
		end
	endtask
	task automatic t_regs();
		chk("gates", gate_o, {$bits(gate_s){1'b1}});
		rd(OFF_CTRL);
		chk("ctrl", d, CTRL_RST);
		rd(OFF_SETTLE);
		chk("settle", d, SETTLE_RST);
		// no lane enabled leaves the word alone, one lane replaces one byte
		wr(OFF_SETTLE, 32'h0, 4'h0);
		rd(OFF_SETTLE);
		chk("strb0", d, SETTLE_RST);
		wr(OFF_SETTLE, 32'h0000_1234, 4'h1);
		rd(OFF_SETTLE);
		chk("strb1", d, {SETTLE_RST[31:8], 8'h34});
		rd(8'h20);
		chk("rresp", rs, RESP_SLVERR);
		wr(OFF_STATUS, 32'h0);
		chk("bresp", rs, RESP_SLVERR);
		$display("regs done");
	endtask
	// every release row; the masked row stays halted until a reset
	task automatic t_halt();
		logic [5:0] r;
		for (int i = 0; i < 6; i++) begin
			r = ROWS[i];
			u_cpu.exec(1'b0);
			u_cpu.flags(1'b1, r[5], r[4], r[3], r[2]);
			wait_res(r[5] ? 30 : 20);
			chk("woke", cpu_resume_o, r[1]);
			if (r[1]) begin
				chk("vec", cpu_vector_o, r[0]);
				chk("wait", c >= (r[0] ? WAIT_VECT_CLK : WAIT_NEXT_CLK) && c <= (r[0] ? 14 : 7), 1);
			end else begin
				chk("held", mode_o, 3'h1);
				rst();
				chk("rst_mode", mode_o, 3'h0);
				chk("rst_cpu", gate_o.cpu_clk_en, 1'b1);
			end
			u_cpu.flags(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		end
		$display("halt done");
	endtask
	task automatic t_stop(input logic [31:0] ctl, per, input logic [6:0] e, input logic wd);
		wr(OFF_SETTLE, 32'h8);
		wr(OFF_CTRL, ctl);
		wr(OFF_PERIPH, per);
		u_cpu.exec(1'b1);
		repeat (2) @(posedge clk_sys_i);
		chk("stop", mode_o, 3'h2);
		chk("per", gate_o[7:1], e);
		chk("wdt", gate_o.wdt_clk_en, wd);
		chk("slow", gate_o.slow_internal_clock_en, 1'b1);
		u_cpu.flags(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		wait_res(40);
		chk("s_res", cpu_resume_o, 1'b1);
		chk("s_vec", cpu_vector_o, 1'b1);
		u_cpu.flags(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("stop done");
	endtask
	// stop with a request already pending, then the event interrupt
	task automatic t_fall();
		u_cpu.flags(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		u_cpu.exec(1'b1);
		@(posedge clk_sys_i);
		chk("fall", mode_o, 3'h4);
		wait_res(40);
		chk("f_res", cpu_resume_o, 1'b1);
		u_cpu.flags(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rd(OFF_IRQ_STAT);
		chk("ev", d[EV_STOP_FALLBACK], 1'b1);
		wr(OFF_IRQ_MASK, 32'h8);
		#1 chk("irq", irq_o, 1'b1);
		wr(OFF_IRQ_STAT, 32'hF);
		#1 chk("clr", irq_o, 1'b0);
		$display("fallback done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		rst();
		t_regs();
		t_halt();
		t_stop(32'h2, 32'h49, 7'h49, 1'b1);
		t_stop(32'h3, 32'hB7, 7'h76, 1'b0);
		t_fall();
		test_done();
	end
	// hang guard, well past the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		test_done();
	end
endmodule
